// file: hw/psel_pkg.sv
// parameter set selector: shared constants, encodings and helper functions
// assumes one core clock; all inputs arrive synchronous to it
package psel_pkg;

  // number of parameter sets and index width
  localparam int unsigned PSEL_NUM_SETS = 8;
  localparam int unsigned PSEL_IDX_W = 3;
  localparam int unsigned PSEL_SEL_W = 4;

  // reset values
  localparam logic [2:0] PSEL_ACTIVE_RST = 3'h0;  // set one active
  localparam logic [3:0] PSEL_SEL_NONE = 4'h0;  // selection code none
  localparam logic [7:0] PSEL_REQ_RST = 8'h00;  // no request seen
  localparam logic [7:0] PSEL_USED_RST = 8'h01;  // only set one in use
  localparam logic [2:0] PSEL_USED_ONE = 3'h0;  // sets_used code for one set

  // last set whose held level blocks lower sets (set eight never blocks)
  localparam logic [2:0] PSEL_LAST_BLOCKER = 3'h6;

  // coarse progress of the selector, for observation
  typedef enum logic [1:0] {
    PSEL_IDLE = 2'b00,  // single set in use
    PSEL_AUTO = 2'b01,  // automatic selection
    PSEL_FORCE = 2'b10  // operator override
  } psel_mode_type;

  // mask of sets in use from the count code (0 means one set)
  function automatic logic [7:0] psel_used_mask(input logic [2:0] cnt);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < PSEL_NUM_SETS; i++) begin
      if (i <= int'(cnt)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : psel_used_mask

  // one-hot of a selection code, none gives zero
  function automatic logic [7:0] psel_sel_onehot(input logic [3:0] sel);
    logic [7:0] m;
    m = 8'h00;
    if (sel != PSEL_SEL_NONE && sel <= 4'h8) begin
      m[3'(sel - 4'h1)] = 1'b1;
    end
    return m;
  endfunction : psel_sel_onehot

endpackage : psel_pkg

// file: hw/psel_prio.sv
// fixed-priority picker: lowest index (highest priority) set wins
// assumes purely combinational use inside the selector
`timescale 1ns/1ps
module psel_prio
  import psel_pkg::*;
(
  input wire logic [7:0] req,  // candidate sets, bit 0 is set one
  output logic found,  // any candidate present
  output logic [2:0] idx  // winning set index
);

  // scan from lowest priority upward so the highest priority is kept
  always_comb begin
    found = 1'b0;
    idx = 3'h0;
    for (int i = PSEL_NUM_SETS - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = 3'(i);
      end
    end
  end

endmodule : psel_prio

// file: hw/psel_top.sv
// parameter set selector: picks the one active set out of up to eight
// assumes all inputs synchronous to core_clk; rstn may assert asynchronously
//
// Operation
// R1 - exactly one of eight sets active
// R2 - reset: only set one, logic idle
// R3 - several sets used: requests decide set
// R4 - override ignores automatic requests, operator chooses
// R5 - request accepted as pulse or level
// R6 - lower set number has higher priority
// R7 - pulse-selected set stays until new request
// R8 - operator enables set and override first
// R9 - override release resumes from held levels
// R10 - active set reported, set one after reset
// R11 - forced choice none or set, pulse-like
// R12 - last forced set stays after release
// R13 - override defaults off, held by operator
// R14 - set count one to eight, defaults loaded
// R15 - remote change blocked by held higher set
// R16 - held set one blocks all others
// R17 - held set k blocks lower sets
// R18 - held set eight blocks nothing
// R19 - flag unused-set and failed force requests
// R20 - flag requests refused by higher priority
// R21 - requests beyond used sets ignored
// R22 - same-cycle requests resolved by priority
`timescale 1ns/1ps
module psel_top
  import psel_pkg::*;
(
  input wire logic core_clk,  // 200 MHz core clock
  input wire logic rstn,  // asynchronous active-low reset
  input wire logic [7:0] set_req,  // request lines, bit 0 is set one
  input wire logic [2:0] sets_used,  // sets in use minus one
  input wire logic override_enable,  // operator override level
  input wire logic [3:0] force_sel,  // forced set, 0 none, 1..8
  input wire logic [3:0] remote_sel,  // remote change, 0 none, 1..8
  output logic [2:0] active_set,  // active set index, 0 is set one
  output logic [7:0] active_onehot,  // active set as one-hot
  output logic [7:0] load_defaults,  // pulse: set newly enabled
  output logic req_fail_unused,  // pulse: request for unused set
  output logic force_fail,  // pulse: forced set not usable
  output logic req_fail_prio,  // pulse: request refused by priority
  output logic [1:0] sel_mode  // idle, auto or forced
);

  // whole state of the selector
  typedef struct packed {
    logic [7:0] req;  // request lines one cycle ago
    logic [3:0] force_sel;  // forced code one cycle ago
    logic [3:0] remote;  // remote code one cycle ago
    logic ovr;  // override level one cycle ago
    logic [2:0] active;  // active set
    logic [7:0] used;  // used mask one cycle ago
    logic [7:0] new_en;  // newly enabled sets
    logic fail_unused;  // request for unused set
    logic fail_force;  // failed forcing
    logic fail_prio;  // refused by priority
    psel_mode_type mode;  // coarse mode
  } psel_state_type;

  psel_state_type st_q;  // registered state
  psel_state_type st_d;  // next state

  logic [1:0] rst_sync_q;  // reset release synchroniser
  logic rst_q;  // synchronised active-low reset

  // release reset through two flops, assert at once
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[1];

  logic [7:0] used_mask;  // sets in use
  logic [7:0] req_edge;  // new request this cycle (pulse start)
  logic [7:0] req_held;  // request high two cycles running (level)
  logic [7:0] remote_oh;  // remote change event as one-hot
  logic [7:0] allowed;  // sets not blocked by a held level
  logic [7:0] auto_req;  // all automatic candidates
  logic [7:0] auto_ok;  // candidates that survive checks
  logic [7:0] new_evt;  // fresh request events only
  logic [7:0] force_oh;  // forced set as one-hot
  logic force_evt;  // operator issues a forced choice
  logic auto_found;  // an automatic winner exists
  logic [2:0] auto_idx;  // automatic winner
  logic blk_found;  // a blocking level exists
  logic [2:0] blk_idx;  // highest-priority blocking level
  logic [7:0] blk_cand;  // held levels allowed to block

  // candidate decoding
  always_comb begin
    used_mask = psel_used_mask(sets_used);  // [R14] [R21]
    req_edge = set_req & ~st_q.req;  // [R5] pulse start
    req_held = set_req & st_q.req;  // [R5] sustained level
    // only sets one up to the last blocker may block lower sets
    blk_cand = 8'h00;
    for (int i = 0; i < PSEL_NUM_SETS; i++) begin
      blk_cand[i] = req_held[i] && (3'(i) <= PSEL_LAST_BLOCKER);  // [R17] [R18]
    end
    // remote code counts once per change to a set
    if (remote_sel != st_q.remote) begin
      remote_oh = psel_sel_onehot(remote_sel);  // [R15]
    end else begin
      remote_oh = 8'h00;
    end
    force_oh = psel_sel_onehot(force_sel);  // [R11]
    // new code, or override just switched on with a code present
    force_evt = override_enable && (force_oh != 8'h00) &&
                ((force_sel != st_q.force_sel) || !st_q.ovr);  // [R11] [R8]
  end

  // highest held level among sets one..seven blocks all lower sets
  psel_prio u_blk (
    .req(blk_cand),  // [R18] set eight never a candidate
    .found(blk_found),
    .idx(blk_idx)
  );

  // allowed sets: the blocker and anything above it
  always_comb begin
    allowed = 8'hFF;
    if (blk_found) begin
      for (int i = 0; i < PSEL_NUM_SETS; i++) begin
        allowed[i] = (3'(i) <= blk_idx);  // [R16] [R17]
      end
    end
  end

  // combine candidates, drop unused and blocked ones
  always_comb begin
    new_evt = req_edge | remote_oh;
    auto_req = req_edge | req_held | remote_oh;  // [R3] [R5]
    auto_ok = auto_req & used_mask & allowed;  // [R21] [R15]
  end

  // priority among everything that survived
  psel_prio u_win (
    .req(auto_ok),  // [R6] [R22]
    .found(auto_found),
    .idx(auto_idx)
  );

  // next state
  always_comb begin
    st_d = st_q;
    st_d.req = set_req;
    st_d.force_sel = force_sel;
    st_d.remote = remote_sel;
    st_d.ovr = override_enable;
    st_d.used = used_mask;
    st_d.new_en = used_mask & ~st_q.used;  // [R14] load defaults pulse
    st_d.fail_unused = 1'b0;
    st_d.fail_force = 1'b0;
    st_d.fail_prio = 1'b0;
    if (sets_used == PSEL_USED_ONE) begin
      // single set: logic idle, set one held
      st_d.mode = PSEL_IDLE;
      st_d.active = PSEL_ACTIVE_RST;  // [R2]
      st_d.fail_unused = |(new_evt & ~used_mask);  // [R19]
      st_d.fail_force = force_evt;  // [R19]
    end else if (override_enable) begin
      // operator owns the selection, automatic requests ignored
      st_d.mode = PSEL_FORCE;  // [R4] [R13]
      if (force_evt) begin
        if ((force_oh & used_mask) != 8'h00) begin
          st_d.active = 3'(force_sel - 4'h1);  // [R11]
        end else begin
          st_d.fail_force = 1'b1;  // [R19]
        end
      end
    end else begin
      // automatic selection; no winner keeps the last set
      st_d.mode = PSEL_AUTO;  // [R3]
      if (auto_found) begin  // [R7] [R12] else last set kept
        st_d.active = auto_idx;  // [R6] [R9]
      end
      st_d.fail_unused = |(new_evt & ~used_mask);  // [R19]
      st_d.fail_prio = |(new_evt & used_mask & ~allowed);  // [R20]
    end
    // count reduced below the active set: fall back to set one
    if (!used_mask[st_d.active]) begin
      st_d.active = PSEL_ACTIVE_RST;  // [R1]
    end
  end

  // register the whole state
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      st_q.req <= PSEL_REQ_RST;
      st_q.force_sel <= PSEL_SEL_NONE;
      st_q.remote <= PSEL_SEL_NONE;
      st_q.ovr <= 1'b0;
      st_q.active <= PSEL_ACTIVE_RST;  // [R2] [R10]
      st_q.used <= PSEL_USED_RST;
      st_q.new_en <= 8'h00;
      st_q.fail_unused <= 1'b0;
      st_q.fail_force <= 1'b0;
      st_q.fail_prio <= 1'b0;
      st_q.mode <= PSEL_IDLE;
    end else begin
      st_q <= st_d;  // [R22] one update per cycle
    end
  end

  // outputs straight from state
  always_comb begin
    active_set = st_q.active;  // [R10]
    active_onehot = 8'h00;
    active_onehot[st_q.active] = 1'b1;  // [R1]
    load_defaults = st_q.new_en;
    req_fail_unused = st_q.fail_unused;
    force_fail = st_q.fail_force;
    req_fail_prio = st_q.fail_prio;
    sel_mode = st_q.mode;
  end

  // active set always within the sets in use
  property p_active_in_use;
    @(posedge core_clk) disable iff (!rst_q)
    st_q.used[active_set];
  endproperty
  a_active_in_use: assert property (p_active_in_use) // [R1]
    else $error("active set outside sets in use");

  // single set in use forces set one
  property p_idle_set_one;
    @(posedge core_clk) disable iff (!rst_q)
    (sets_used == PSEL_USED_ONE) |=> (active_set == 3'h0) && (sel_mode == 2'b00);
  endproperty
  a_idle_set_one: assert property (p_idle_set_one) // [R2]
    else $error("idle selector left set one");

  // override without a forced choice keeps the set
  property p_override_holds;
    @(posedge core_clk) disable iff (!rst_q)
    (override_enable && !force_evt && sets_used != PSEL_USED_ONE &&
     used_mask[active_set]) |=> $stable(active_set);
  endproperty
  a_override_holds: assert property (p_override_holds) // [R4]
    else $error("set changed under override without forcing");

  // valid forced choice lands next cycle
  property p_force_lands;
    @(posedge core_clk) disable iff (!rst_q)
    (force_evt && sets_used != PSEL_USED_ONE && (force_oh & used_mask) != 8'h00)
      |=> (active_set == $past(force_sel[2:0]) - 3'h1) && !force_fail;
  endproperty
  a_force_lands: assert property (p_force_lands) // [R11]
    else $error("forced set not taken");

  // unusable forced choice is flagged
  property p_force_fail;
    @(posedge core_clk) disable iff (!rst_q)
    (force_evt && (force_oh & used_mask) == 8'h00) |=> force_fail;
  endproperty
  a_force_fail: assert property (p_force_fail) // [R19]
    else $error("failed forcing not flagged");

  // held set one wins the next cycle in automatic mode
  property p_set_one_held;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && req_held[0]) |=> (active_set == 3'h0);
  endproperty
  a_set_one_held: assert property (p_set_one_held) // [R16]
    else $error("held set one did not hold");

  // automatic winner is the highest surviving candidate
  property p_auto_winner;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && sets_used != PSEL_USED_ONE && auto_found)
      |=> (active_set == $past(auto_idx));
  endproperty
  a_auto_winner: assert property (p_auto_winner) // [R6]
    else $error("automatic winner not taken");

  // no candidate leaves the pulse-selected set alone
  property p_pulse_sticks;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && !auto_found && used_mask[active_set]) |=> $stable(active_set);
  endproperty
  a_pulse_sticks: assert property (p_pulse_sticks) // [R7]
    else $error("set changed without request");

  // fresh request to unused set is flagged without override
  property p_unused_flag;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && (new_evt & ~used_mask) != 8'h00) |=> req_fail_unused;
  endproperty
  a_unused_flag: assert property (p_unused_flag) // [R19]
    else $error("request for unused set not flagged");

  // blocked fresh request is flagged
  property p_prio_flag;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && sets_used != PSEL_USED_ONE &&
     (new_evt & used_mask & ~allowed) != 8'h00) |=> req_fail_prio;
  endproperty
  a_prio_flag: assert property (p_prio_flag) // [R20]
    else $error("blocked request not flagged");

  // one-hot output always names the active index
  property p_onehot_match;
    @(posedge core_clk) disable iff (!rst_q)
    $onehot(active_onehot) && active_onehot[active_set];
  endproperty
  a_onehot_match: assert property (p_onehot_match) // [R1]
    else $error("active set output not one-hot");

  // held level on set k keeps the result at k or above
  property p_held_blocks_lower;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && sets_used != PSEL_USED_ONE && blk_found)
      |=> (active_set <= $past(blk_idx));
  endproperty
  a_held_blocks_lower: assert property (p_held_blocks_lower) // [R17]
    else $error("held level let a lower set through");

  // held set eight alone never refuses a fresh request
  property p_eight_never_blocks;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && sets_used != PSEL_USED_ONE && req_held == 8'h80 &&
     (new_evt & used_mask) != 8'h00) |=> !req_fail_prio;
  endproperty
  a_eight_never_blocks: assert property (p_eight_never_blocks) // [R18]
    else $error("held set eight blocked a request");

  // override: forced mode, automatic requests raise no flags
  property p_override_quiet;
    @(posedge core_clk) disable iff (!rst_q)
    (override_enable && sets_used != PSEL_USED_ONE)
      |=> !req_fail_unused && !req_fail_prio && (sel_mode == PSEL_FORCE);
  endproperty
  a_override_quiet: assert property (p_override_quiet) // [R4]
    else $error("automatic request acted under override");

  // remote change below a held higher set is refused
  property p_remote_blocked;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && sets_used != PSEL_USED_ONE &&
     (remote_oh & used_mask & ~allowed) != 8'h00)
      |=> req_fail_prio && (active_set <= $past(blk_idx));
  endproperty
  a_remote_blocked: assert property (p_remote_blocked) // [R15]
    else $error("remote change passed a held higher set");

  // override released with nothing requesting keeps the forced set
  property p_release_keeps;
    @(posedge core_clk) disable iff (!rst_q)
    (!override_enable && st_q.ovr && !auto_found && used_mask[active_set])
      |=> $stable(active_set);
  endproperty
  a_release_keeps: assert property (p_release_keeps) // [R12]
    else $error("forced set lost after override release");

endmodule : psel_top

// file: bench/psel_req_model.sv
// request source model: protection logic, digital inputs, operator and remote link
// assumes the selector samples on the rising edge; all drives change on the falling edge
`timescale 1ns/1ps
module psel_req_model
  import psel_pkg::*;
(
  input wire logic core_clk,  // core clock
  output logic [7:0] set_req,  // request lines, bit 0 is set one
  output logic override_enable,  // operator override level
  output logic [3:0] force_sel,  // forced set code
  output logic [3:0] remote_sel  // remote change code
);
  logic [7:0] hold_mask;  // lines kept at a static level

  // quiet lines at time zero
  initial begin
    set_req = 8'h00;
    hold_mask = 8'h00;
    override_enable = 1'b0;
    force_sel = 4'h0;
    remote_sel = 4'h0;
  end

  // one-cycle pulse on top of the held lines
  task automatic pulse(input logic [7:0] mask);
    @(negedge core_clk);
    set_req = hold_mask | mask;
    @(negedge core_clk);
    set_req = hold_mask;
  endtask : pulse

  // static level, kept until changed
  task automatic hold(input logic [7:0] mask);
    @(negedge core_clk);
    hold_mask = mask;
    set_req = mask;
  endtask : hold

  // operator: override level together with the wanted set
  task automatic force_set(input logic [3:0] code, input logic en);
    @(negedge core_clk);
    override_enable = en;
    force_sel = code;
    @(negedge core_clk);
  endtask : force_set

  // remote link: new change code, answer seen one cycle later
  task automatic remote(input logic [3:0] code);
    @(negedge core_clk);
    remote_sel = code;
    @(negedge core_clk);
  endtask : remote
endmodule : psel_req_model

// file: bench/psel_tb.sv
// testbench for the parameter set selector: sequences of request calls with checks
// assumes the request model drives every request input on the falling edge
`timescale 1ns/1ps
module testbench;
  import psel_pkg::*;

  logic core_clk;  // 200 MHz clock
  logic rstn;  // active-low reset
  logic [2:0] sets_used;  // sets in use minus one
  logic [7:0] set_req;  // from the model
  logic override_enable;  // from the model
  logic [3:0] force_sel;  // from the model
  logic [3:0] remote_sel;  // from the model
  logic [2:0] active_set;  // active set index
  logic [7:0] active_onehot;  // active set one-hot
  logic [7:0] load_defaults;  // newly used sets
  logic req_fail_unused;  // unused set flag
  logic force_fail;  // failed force flag
  logic req_fail_prio;  // priority refusal flag
  logic [1:0] sel_mode;  // idle, auto, forced
  int n_fail;  // mismatches
  int samples_checked;  // comparisons
  int cycles;  // timeout counter

  psel_req_model partner (
    .core_clk(core_clk), .set_req(set_req), .override_enable(override_enable),
    .force_sel(force_sel), .remote_sel(remote_sel)
  );

  psel_top dut (
    .core_clk(core_clk), .rstn(rstn), .set_req(set_req), .sets_used(sets_used),
    .override_enable(override_enable), .force_sel(force_sel), .remote_sel(remote_sel),
    .active_set(active_set), .active_onehot(active_onehot), .load_defaults(load_defaults),
    .req_fail_unused(req_fail_unused), .force_fail(force_fail),
    .req_fail_prio(req_fail_prio), .sel_mode(sel_mode)
  );

  // clock, half period 2.5 ns
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // compare one value
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // compare one flag
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // compare the mode code
  task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_mode

  // compare a set index
  task automatic chk_idx(input logic [2:0] got, input logic [2:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_idx

  // active index and its one-hot agree with the expected set
  task automatic chk_act(input logic [2:0] exp);
    chk_idx(active_set, exp);
    chk(active_onehot, 8'h01 << exp);
  endtask : chk_act

  // let some falling edges pass
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    rstn = 1'b0;
    sets_used = 3'h0;
    wait_n(12);
    rstn = 1'b1;
    wait_n(4);
    // out of reset: set one, idle
    chk_act(3'h0);
    chk_mode(sel_mode, 2'h0);
    // one set in use: request for set three refused
    partner.pulse(8'h04);
    chk_bit(req_fail_unused, 1'b1);
    chk_act(3'h0);
    // all eight sets: newly used sets get defaults
    @(negedge core_clk);
    sets_used = 3'h7;
    for (int i = 0; i < 4 && load_defaults === 8'h00; i++) begin
      @(negedge core_clk);
    end
    chk(load_defaults, 8'hFE);
    wait_n(2);
    chk_mode(sel_mode, 2'h1);
    // pulse selects and stays
    partner.pulse(8'h04);
    chk_act(3'h2);
    wait_n(3);
    chk_act(3'h2);
    // same-cycle pulses: lower number wins
    partner.pulse(8'h28);
    chk_act(3'h3);
    // held set two blocks set six
    partner.hold(8'h02);
    wait_n(2);
    chk_act(3'h1);
    partner.pulse(8'h20);
    chk_bit(req_fail_prio, 1'b1);
    chk_act(3'h1);
    // held set one blocks remote change
    partner.hold(8'h01);
    wait_n(2);
    partner.remote(4'h5);
    chk_act(3'h0);
    chk_bit(req_fail_prio, 1'b1);
    partner.remote(4'h0);
    // held set eight blocks nothing
    partner.hold(8'h80);
    wait_n(2);
    chk_act(3'h7);
    partner.pulse(8'h10);
    chk_act(3'h4);
    chk_bit(req_fail_prio, 1'b0);
    // override wins over held set two, ignores pulses
    partner.hold(8'h02);
    wait_n(2);
    partner.force_set(4'h6, 1'b1);
    chk_act(3'h5);
    chk_mode(sel_mode, 2'h2);
    partner.pulse(8'h01);
    chk_act(3'h5);
    wait_n(3);
    chk_mode(sel_mode, 2'h2);
    partner.force_set(4'h0, 1'b0);
    chk_act(3'h1);
    // last forced set stays when nothing requests
    partner.hold(8'h00);
    wait_n(2);
    partner.force_set(4'h3, 1'b1);
    chk_act(3'h2);
    partner.force_set(4'h0, 1'b0);
    wait_n(3);
    chk_act(3'h2);
    // set eight forced, then set seven by pulse
    partner.force_set(4'h8, 1'b1);
    chk_act(3'h7);
    partner.force_set(4'h0, 1'b0);
    partner.pulse(8'h40);
    chk_act(3'h6);
    // held set seven blocks set eight
    partner.hold(8'h40);
    wait_n(2);
    partner.pulse(8'h80);
    chk_bit(req_fail_prio, 1'b1);
    chk_act(3'h6);
    partner.hold(8'h00);
    // four sets in use: set seven falls back, force and remote beyond them
    @(negedge core_clk);
    sets_used = 3'h3;
    wait_n(2);
    chk_act(3'h0);
    partner.force_set(4'h7, 1'b1);
    chk_bit(force_fail, 1'b1);
    partner.force_set(4'h0, 1'b0);
    partner.remote(4'h4);
    chk_act(3'h3);
    partner.remote(4'h8);
    chk_bit(req_fail_unused, 1'b1);
    chk_act(3'h3);
    partner.remote(4'h0);
    // reset in mid-run: set one again, newly used sets reloaded
    rstn = 1'b0;
    wait_n(2);
    chk_act(3'h0);
    chk_mode(sel_mode, 2'h0);
    rstn = 1'b1;
    wait_n(3);
    chk(load_defaults, 8'h0E);
    wait_n(1);
    chk_mode(sel_mode, 2'h1);
    chk_act(3'h0);
    tally_and_finish();
  end
endmodule : testbench
